// file: wpw_core.sv
// Purpose: write protection, status word and burst memory write of a serial memory slave
// Assumes: serial clock is a clock of its own; status changes only while chip select is high
// Notes:   array itself sits outside; committed bytes leave on mem_wr_out
//
// What this block does
// R1: latch-clear command clears the write latch
// R2: status bits 7,3,2,1 are enable, guards, latch
// R3: bits 0,4,5 read zero, bit 6 one
// R4: write latch is zero after power-up
// R5: full status write clears the latch flag, even if refused
// R6: block-guard bits survive power cycles
// R7: guard code picks none, quarter, half, all
// R8: protect pin ignored when pin enable clear
// R9: status write refused when enable set, pin low
// R10: array write needs latch, address outside guard
// R11: protect pin never blocks array writes
// R12: status-read shifts status byte out
// R13: status write needs latch, then clears it
// R14: master keeps protect pin high before status write; the bench drives it low before some status writes
// R15: latch-set frame, opcode, three address bytes, 18 bits
// R16: successive bytes to successive addresses, wrapping
// R17: data bytes arrive msb first, eight clocks
// R18: byte committed after eighth clock only
// R19: protected address stops burst, drops rest
// R20: bursts run at bus speed, unbuffered
// R21: latch-set command sets the write latch
// R22: latch cleared at chip-select rise after writes
// R23: sample on rising, drive on falling clock
// R24: unknown opcode ignores frame, output tristated
// R25: status updated only after full data byte
`timescale 1ns/1ps

module wpw_core
    import wpw_pkg::*;
(
    // system
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    // serial link
    input  wire logic              link_sck_in,
    input  wire logic              cs_n_in,
    input  wire logic              si_in,
    output logic                   so_out,
    output logic                   so_oe_out,
    input  wire logic              wp_n_in,
    // array write port
    output logic                   mem_wr_out,
    output logic [ADDR_W-1:0]      mem_addr_out,
    output logic [7:0]             mem_data_out,
    // nonvolatile guard storage and status view
    input  wire logic [1:0]        nv_guard_in,
    output logic [1:0]             nv_guard_out,
    output logic [7:0]             status_out
);

    function automatic logic guard_hit(input logic [1:0] code, input logic [ADDR_W-1:0] a);
        case (code)
            GUARD_NONE: guard_hit = 1'b0;
            GUARD_QTR:  guard_hit = (a[ADDR_W-1:ADDR_W-2] == QTR_TOP);
            GUARD_HALF: guard_hit = a[ADDR_W-1];
            GUARD_ALL:  guard_hit = 1'b1;
            default:    guard_hit = 1'b1;
        endcase
    endfunction

    // core-domain status
    wpw_status_s        status_reg;

    // link domain
    wpw_link_e          state_reg;
    logic [2:0]         bit_cnt_reg;
    logic [1:0]         addr_cnt_reg;
    logic [6:0]         shift_reg;
    logic [ADDR_W-1:0]  addr_reg;
    logic [ADDR_W-1:0]  cmt_addr_reg;
    logic [7:0]         cmt_data_reg;
    logic               wr_tgl_reg;
    logic               frm_set_reg;
    logic               frm_clr_reg;
    logic               frm_sw_reg;
    logic [7:0]         sw_data_reg;
    logic [7:0]         byte_in;
    logic               byte_done;
    logic               first_edge;
    logic               wr_ok;
    logic [1:0]         guard_code;

    // core-domain crossings
    logic               cs_s1_reg;
    logic               cs_s2_reg;
    logic               cs_s3_reg;
    logic               tg_s1_reg;
    logic               tg_s2_reg;
    logic               tg_s3_reg;
    logic               wp_s1_reg;
    logic               wp_s2_reg;
    logic [1:0]         nv_s1_reg;
    logic [1:0]         nv_s2_reg;
    logic [1:0]         nv_cnt_reg;
    logic               cs_rise;
    logic               wr_evt;
    logic               sw_allowed;

    assign byte_in    = {shift_reg, si_in};                              // see R17
    assign byte_done  = (bit_cnt_reg == 3'h7);                           // see R18
    assign first_edge = (state_reg == ST_OPC) && (bit_cnt_reg == 3'h0);
    assign guard_code = {status_reg.guard_hi, status_reg.guard_lo};
    // pin plays no part in array writes
    assign wr_ok      = status_reg.write_latch_flag && !guard_hit(guard_code, addr_reg); // see R10 R11 R7

    // ---------------- link domain, rising edge ----------------

    // bit counter and command state, cleared while deselected
    always_ff @(posedge link_sck_in or posedge cs_n_in or negedge rst_n_in) begin
        if (!rst_n_in || cs_n_in) begin
            bit_cnt_reg  <= 3'h0;
            addr_cnt_reg <= 2'h0;
            state_reg    <= ST_OPC;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;                           // see R23
            if (byte_done) begin
                case (state_reg)
                    ST_OPC: begin
                        case (byte_in)
                            OPC_STATUS_READ:  state_reg <= ST_STATUS_READ_CMD;
                            OPC_STATUS_WRITE: state_reg <= ST_SWDAT;
                            OPC_MEM_WRITE:    state_reg <= ST_ADDR;      // see R15
                            default:          state_reg <= ST_IGNORE;    // see R24
                        endcase
                    end
                    ST_ADDR: begin
                        addr_cnt_reg <= addr_cnt_reg + 2'h1;
                        if (addr_cnt_reg == ADDR_BYTES - 2'h1) begin
                            state_reg <= ST_MEMDAT;
                        end
                    end
                    ST_MEMDAT: begin
                        if (!wr_ok) begin
                            state_reg <= ST_IGNORE;                      // see R19
                        end
                    end
                    ST_SWDAT:  state_reg <= ST_IGNORE;
                    ST_STATUS_READ_CMD:   state_reg <= ST_IGNORE;
                    default:   state_reg <= ST_IGNORE;
                endcase
            end
        end
    end

    // serial input shifter
    always_ff @(posedge link_sck_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_reg <= 7'h00;
        end else begin
            shift_reg <= byte_in[6:0];                                   // see R17
        end
    end

    // address counter and byte commit, one byte per eight clocks
    always_ff @(posedge link_sck_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_reg     <= '0;
            cmt_addr_reg <= '0;
            cmt_data_reg <= 8'h00;
            wr_tgl_reg   <= 1'b0;
        end else if (!cs_n_in && byte_done) begin
            if (state_reg == ST_ADDR) begin
                addr_reg <= {addr_reg[ADDR_W-9:0], byte_in};             // see R15
            end else if (state_reg == ST_MEMDAT && wr_ok) begin
                cmt_addr_reg <= addr_reg;                                // see R18 R20
                cmt_data_reg <= byte_in;
                wr_tgl_reg   <= !wr_tgl_reg;
                addr_reg     <= addr_reg + ADDR_ONE;                     // see R16
            end
        end
    end

    // frame summary, held until the next frame's first clock
    always_ff @(posedge link_sck_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            frm_set_reg <= 1'b0;
            frm_clr_reg <= 1'b0;
            frm_sw_reg  <= 1'b0;
            sw_data_reg <= 8'h00;
        end else if (!cs_n_in) begin
            if (first_edge) begin
                frm_set_reg <= 1'b0;
                frm_clr_reg <= 1'b0;
                frm_sw_reg  <= 1'b0;
            end else if (byte_done && state_reg == ST_OPC) begin
                frm_set_reg <= (byte_in == OPC_LATCH_SET);               // see R21
                frm_clr_reg <= (byte_in == OPC_LATCH_CLEAR)
                             || (byte_in == OPC_MEM_WRITE)
                             || (byte_in == OPC_SECTOR_WRITE)
                             || (byte_in == OPC_SERNUM_WRITE);           // see R1 R22
            end else if (byte_done && state_reg == ST_SWDAT) begin
                frm_sw_reg  <= 1'b1;                                     // see R25
                sw_data_reg <= byte_in;
            end
        end
    end

    // ---------------- link domain, falling edge ----------------

    // serial output only during the status byte
    always_ff @(negedge link_sck_in or posedge cs_n_in or negedge rst_n_in) begin
        if (!rst_n_in || cs_n_in) begin
            so_out    <= 1'b0;
            so_oe_out <= 1'b0;
        end else if (state_reg == ST_STATUS_READ_CMD) begin
            so_out    <= status_reg[3'h7 - bit_cnt_reg];                 // see R12 R23
            so_oe_out <= 1'b1;
        end else begin
            so_out    <= 1'b0;
            so_oe_out <= 1'b0;                                           // see R24
        end
    end

    // ---------------- core domain ----------------

    assign cs_rise    = cs_s2_reg && !cs_s3_reg;
    assign wr_evt     = tg_s2_reg ^ tg_s3_reg;
    // pin only counts while its enable is set
    assign sw_allowed = status_reg.write_latch_flag && !(status_reg.pin_en && !wp_s2_reg); // see R8 R9

    // samplers for chip select, commit toggle, protect pin, stored guard
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            tg_s1_reg <= 1'b0;
            tg_s2_reg <= 1'b0;
            tg_s3_reg <= 1'b0;
            wp_s1_reg <= 1'b1;
            wp_s2_reg <= 1'b1;
            nv_s1_reg <= 2'h0;
            nv_s2_reg <= 2'h0;
        end else begin
            cs_s1_reg <= cs_n_in;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            tg_s1_reg <= wr_tgl_reg;
            tg_s2_reg <= tg_s1_reg;
            tg_s3_reg <= tg_s2_reg;
            wp_s1_reg <= wp_n_in;
            wp_s2_reg <= wp_s1_reg;
            nv_s1_reg <= nv_guard_in;
            nv_s2_reg <= nv_s1_reg;
        end
    end

    // array write strobe with held address and data
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_wr_out   <= 1'b0;
            mem_addr_out <= '0;
            mem_data_out <= 8'h00;
        end else begin
            mem_wr_out <= wr_evt;                                        // see R18
            if (wr_evt) begin
                mem_addr_out <= cmt_addr_reg;
                mem_data_out <= cmt_data_reg;
            end
        end
    end

    // nonvolatile guard load after reset release
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nv_cnt_reg <= 2'h0;
        end else if (nv_cnt_reg != NV_LOAD_CNT + 2'h1) begin
            nv_cnt_reg <= nv_cnt_reg + 2'h1;
        end
    end

    // status word, changed at the guard load and after chip select rises
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_reg <= STATUS_RESET;                                  // see R3 R4
        end else if (nv_cnt_reg == NV_LOAD_CNT) begin
            status_reg.guard_hi <= nv_s2_reg[1];                         // see R6
            status_reg.guard_lo <= nv_s2_reg[0];
        end else if (cs_rise) begin
            if (frm_set_reg) begin
                status_reg.write_latch_flag <= 1'b1;                                  // see R21
            end else if (frm_clr_reg) begin
                status_reg.write_latch_flag <= 1'b0;                                  // see R1 R22
            end else if (frm_sw_reg) begin
                status_reg.write_latch_flag <= 1'b0;                                  // see R5 R13
                if (sw_allowed) begin
                    status_reg.pin_en   <= sw_data_reg[BIT_PIN_EN];      // see R2 R9
                    status_reg.guard_hi <= sw_data_reg[BIT_GUARD_HI];
                    status_reg.guard_lo <= sw_data_reg[BIT_GUARD_LO];
                end
            end
        end
    end

    assign status_out   = status_reg;
    assign nv_guard_out = guard_code;

    // ---------------- checks ----------------

    a_fixed_bits: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // see R3
        status_reg.fix_one && status_reg.fix_zero_hi == 2'h0 && !status_reg.fix_zero_lo)
        else $error("fixed status bits changed");

    a_wel_powerup: assert property (@(posedge ref_clk_in) // see R4
        $rose(rst_n_in) |-> !status_reg.write_latch_flag)
        else $error("write latch not clear after power-up");

    a_latch_set_frame: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // see R21
        cs_rise && frm_set_reg && nv_cnt_reg != NV_LOAD_CNT |=> status_reg.write_latch_flag)
        else $error("latch-set frame did not set latch");

    a_latch_clr_frame: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // see R22
        cs_rise && !frm_set_reg && (frm_clr_reg || frm_sw_reg) |=> !status_reg.write_latch_flag)
        else $error("write frame did not clear latch");

    a_sw_refused: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // see R9
        cs_rise && frm_sw_reg && status_reg.pin_en && !wp_s2_reg
        |=> $stable(guard_code) && $stable(status_reg.pin_en))
        else $error("status write taken while pin guards it");

    a_sw_applied: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // see R13
        cs_rise && frm_sw_reg && !frm_set_reg && !frm_clr_reg && sw_allowed
        && nv_cnt_reg != NV_LOAD_CNT
        |=> guard_code == $past(sw_data_reg[BIT_GUARD_HI:BIT_GUARD_LO]))
        else $error("status write not applied");

    a_burst_step: assert property (@(posedge link_sck_in) // see R16
        disable iff (cs_n_in || !rst_n_in)
        byte_done && state_reg == ST_MEMDAT && wr_ok
        |=> addr_reg == $past(addr_reg) + ADDR_ONE && wr_tgl_reg != $past(wr_tgl_reg))
        else $error("burst address or commit missing");

    a_guard_stop: assert property (@(posedge link_sck_in) // see R19
        disable iff (cs_n_in || !rst_n_in)
        byte_done && state_reg == ST_MEMDAT && !wr_ok
        |=> state_reg == ST_IGNORE && $stable(wr_tgl_reg) && $stable(addr_reg))
        else $error("protected byte was written");

    a_status_shift: assert property (@(negedge link_sck_in) // see R12
        disable iff (cs_n_in || !rst_n_in)
        state_reg == ST_STATUS_READ_CMD && bit_cnt_reg == 3'h0
        |=> so_oe_out && so_out == status_reg.pin_en)
        else $error("status byte msb not driven");

    a_mem_strobe: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // see R18
        wr_evt |=> mem_wr_out && mem_data_out == $past(cmt_data_reg) ##1 !mem_wr_out)
        else $error("array strobe wrong");

    a_nv_load: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // see R6
        nv_cnt_reg == NV_LOAD_CNT |=> guard_code == $past(nv_s2_reg))
        else $error("stored guard bits not loaded");

    a_pin_ignored: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // see R8
        cs_rise && frm_sw_reg && !frm_set_reg && !frm_clr_reg && status_reg.write_latch_flag
        && !status_reg.pin_en && nv_cnt_reg != NV_LOAD_CNT
        |=> status_reg.pin_en == $past(sw_data_reg[BIT_PIN_EN]))
        else $error("status write blocked with pin enable clear");

    a_quiet_frame: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // see R25
        cs_rise && !frm_set_reg && !frm_clr_reg && !frm_sw_reg
        && nv_cnt_reg != NV_LOAD_CNT |=> $stable(status_reg))
        else $error("status changed by a non-writing frame");

    a_so_quiet: assert property (@(negedge link_sck_in) // see R24
        disable iff (cs_n_in || !rst_n_in)
        state_reg == ST_IGNORE |=> !so_oe_out)
        else $error("serial output driven in ignored frame");

    a_guard_all: assert property (@(posedge link_sck_in) // see R7
        disable iff (cs_n_in || !rst_n_in)
        byte_done && state_reg == ST_MEMDAT && guard_code == GUARD_ALL |=> $stable(wr_tgl_reg))
        else $error("write taken with whole array guarded");

    c_mem_burst: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        mem_wr_out ##[1:100] mem_wr_out);
    c_sw_done: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        cs_rise && frm_sw_reg && sw_allowed);
    c_sw_refused: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        cs_rise && frm_sw_reg && status_reg.write_latch_flag && !sw_allowed);
    c_status_read: cover property (@(negedge link_sck_in) disable iff (cs_n_in || !rst_n_in)
        state_reg == ST_STATUS_READ_CMD && bit_cnt_reg == 3'h7);
    c_addr_wrap: cover property (@(posedge link_sck_in) disable iff (cs_n_in || !rst_n_in)
        byte_done && state_reg == ST_MEMDAT && wr_ok && addr_reg == '1);

endmodule

// file: wpw_pkg.sv
// Purpose: shared constants and types for the serial memory write-guard block
// Assumes: 8-bit status word, 18-bit array address
// Notes:   opcodes, status layout and guard codes live here only
package wpw_pkg;

    // opcodes
    localparam logic [7:0] OPC_LATCH_SET    = 8'h06;
    localparam logic [7:0] OPC_LATCH_CLEAR  = 8'h04;
    localparam logic [7:0] OPC_STATUS_READ  = 8'h05;
    localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OPC_MEM_WRITE    = 8'h02;
    localparam logic [7:0] OPC_SECTOR_WRITE = 8'h42;
    localparam logic [7:0] OPC_SERNUM_WRITE = 8'hC2;

    // array address
    localparam int              ADDR_W     = 18;
    localparam logic [17:0]     ADDR_ONE   = 18'h00001;
    localparam logic [1:0]      ADDR_BYTES = 2'h3;
    localparam logic [1:0]      QTR_TOP    = 2'h3;

    // status bit positions
    localparam int BIT_PIN_EN   = 7;
    localparam int BIT_GUARD_HI = 3;
    localparam int BIT_GUARD_LO = 2;

    // block-guard codes
    localparam logic [1:0] GUARD_NONE  = 2'h0;
    localparam logic [1:0] GUARD_QTR   = 2'h1;
    localparam logic [1:0] GUARD_HALF  = 2'h2;
    localparam logic [1:0] GUARD_ALL   = 2'h3;

    // nonvolatile load waits for the two-stage sampler
    localparam logic [1:0] NV_LOAD_CNT = 2'h2;

    // status word layout, bit 7 first
    typedef struct packed {
        logic       pin_en;
        logic       fix_one;
        logic [1:0] fix_zero_hi;
        logic       guard_hi;
        logic       guard_lo;
        logic       write_latch_flag;
        logic       fix_zero_lo;
    } wpw_status_s;

    localparam wpw_status_s STATUS_RESET = 8'h40;

    // link-side command states
    typedef enum logic [2:0] {
        ST_OPC    = 3'b000,
        ST_ADDR   = 3'b001,
        ST_MEMDAT = 3'b010,
        ST_SWDAT  = 3'b011,
        ST_STATUS_READ_CMD   = 3'b100,
        ST_IGNORE = 3'b101
    } wpw_link_e;

endpackage

// file: wpw_spi_master.sv
// Purpose: spi bus master model for the serial link of the write-guard block
// Assumes: 15 ns serial clock that runs only inside frames
// Notes:   tx_q holds the bytes to send, rx_byte the last eight bits seen on so
`timescale 1ns/1ps

module wpw_spi_master (
    // serial link
    output logic      sck_out,
    output logic      cs_n_out,
    output logic      si_out,
    input  wire logic so_in,
    input  wire logic so_oe_in
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_byte;
    logic       oe_seen;

    initial begin
        sck_out  = 1'b0;
        cs_n_out = 1'b1;
        si_out   = 1'b0;
    end

    // one frame of nbits, msb first; mode3 idles the clock high
    task automatic frame(input int nbits, input bit mode3);
        logic [7:0] cur;
        sck_out = mode3;
        #3.1;
        cs_n_out = 1'b0;
        oe_seen  = 1'b0;
        rx_byte  = 8'h00;
        cur      = 8'h00;
        #7.5;
        for (int i = 0; i < nbits; i++) begin
            if (i % 8 == 0) begin
                cur = (tx_q.size() > 0) ? tx_q.pop_front() : 8'h00;
            end
            sck_out = 1'b0;
            si_out  = cur[7 - i % 8];
            #7.5;
            sck_out = 1'b1;
            rx_byte = {rx_byte[6:0], so_in};
            oe_seen = oe_seen | so_oe_in;
            #7.5;
        end
        sck_out = mode3;
        #7.5;
        cs_n_out = 1'b1;
        si_out   = ~si_out;
        tx_q.delete();
        #40;
    endtask
endmodule

// file: test_spi_fram_write_protect_and_write.sv
// Purpose: self-checking bench for the write-guard core against a reference model
// Assumes: spi master model on the link, array strobes watched on the core clock
// Notes:   guard storage input held static after reset
`timescale 1ns/1ps

module test_spi_fram_write_protect_and_write
    import wpw_pkg::*;
;
    logic              ref_clk_in;
    logic              rst_n_in;
    logic              sck;
    logic              cs_n;
    logic              si;
    logic              so;
    logic              so_oe;
    logic              wp_n;
    logic              mem_wr;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0]        mem_data;
    logic [1:0]        nv_in;
    logic [1:0]        nv_out;
    logic [7:0]        status;
    int                err_total;
    int                cmp_count;
    logic [31:0]       seed;
    logic              pin_en_m;
    logic              wel_m;
    logic [1:0]        guard_m;
    logic [25:0]       exp_q[$];

    wpw_core dut_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .link_sck_in(sck),
        .cs_n_in(cs_n), .si_in(si), .so_out(so), .so_oe_out(so_oe), .wp_n_in(wp_n),
        .mem_wr_out(mem_wr), .mem_addr_out(mem_addr), .mem_data_out(mem_data),
        .nv_guard_in(nv_in), .nv_guard_out(nv_out), .status_out(status));
    wpw_spi_master mst_u (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so),
        .so_oe_in(so_oe));

    always #2 ref_clk_in = ~ref_clk_in;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] stat_m();
        return {pin_en_m, 1'b1, 2'b00, guard_m, wel_m, 1'b0};
    endfunction

    function automatic bit prot(input logic [17:0] a);
        case (guard_m)
            GUARD_QTR:  return a >= 18'h30000;
            GUARD_HALF: return a >= 18'h20000;
            GUARD_ALL:  return 1'b1;
            default:    return 1'b0;
        endcase
    endfunction

    task automatic stop_test();
        $display("comparisons %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_stat(input string name, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_mem(input logic [25:0] e, input logic [25:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("Error mem_write expected %h seen %h", e, g);
        end
    endtask

    task automatic chk_all();
        chk_stat("status_out", stat_m(), status);
        chk_stat("nv_guard_out", {6'h00, guard_m}, {6'h00, nv_out});
    endtask

    // array strobes checked against the expected queue
    always @(negedge ref_clk_in) begin
        if (rst_n_in === 1'b1 && mem_wr !== 1'b0) begin
            chk_mem(exp_q.size() > 0 ? exp_q.pop_front() : 26'bx, {mem_addr, mem_data});
        end
    end

    task automatic latch_set();
        mst_u.tx_q.push_back(OPC_LATCH_SET);
        mst_u.frame(8, 1'b0);
        wel_m = 1'b1;
    endtask

    task automatic set_wp(input logic v);
        @(negedge ref_clk_in);
        wp_n = v;
    endtask

    task automatic status_wr(input logic [7:0] v, input int nbits);
        latch_set();
        mst_u.tx_q.push_back(OPC_STATUS_WRITE);
        mst_u.tx_q.push_back(v);
        mst_u.frame(nbits, 1'b0);
        if (nbits >= 16) begin
            if (wel_m && !(pin_en_m && !wp_n)) begin
                pin_en_m = v[BIT_PIN_EN];
                guard_m  = v[BIT_GUARD_HI:BIT_GUARD_LO];
            end
            wel_m = 1'b0;
        end
    endtask

    task automatic read_status(input bit m3);
        mst_u.tx_q.push_back(OPC_STATUS_READ);
        mst_u.frame(16, m3);
        chk_stat("status_read", stat_m(), mst_u.rx_byte);
    endtask

    task automatic mem_burst(input logic [23:0] a24, input int n, input int extra);
        logic [17:0] a;
        logic [31:0] r;
        bit          stop;
        a    = a24[17:0];
        stop = 1'b0;
        mst_u.tx_q = {OPC_MEM_WRITE, a24[23:16], a24[15:8], a24[7:0]};
        for (int i = 0; i <= n; i++) begin
            r = rnd();
            mst_u.tx_q.push_back(r[7:0]);
            if (prot(a)) stop = 1'b1;
            if (i < n && wel_m && !stop) begin
                exp_q.push_back({a, r[7:0]});
                a = a + ADDR_ONE;
            end
        end
        mst_u.frame(32 + 8 * n + extra, 1'b0);
        wel_m = 1'b0;
    endtask

    initial begin
        #200000;
        err_total++;
        stop_test();
    end

    initial begin
        logic [31:0]      r;
        logic [7:0]       v;
        logic [17:0]      starts[4];
        logic [7:0]       bad_ops[5];
        ref_clk_in = 1'b0;
        rst_n_in   = 1'b0;
        wp_n       = 1'b1;
        err_total  = 0;
        cmp_count  = 0;
        seed       = 32'h00000016;
        r          = rnd();
        nv_in      = r[1:0];
        pin_en_m   = 1'b0;
        wel_m      = 1'b0;
        starts     = '{18'h3FFFE, 18'h2FFFE, 18'h1FFFE, 18'h00010};
        bad_ops    = '{8'h03, 8'h0B, 8'h42, 8'h9F, 8'hC2};
        repeat (3) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        guard_m  = nv_in;
        repeat (6) @(negedge ref_clk_in);
        chk_all();
        mem_burst(24'h000100, 2, 0);
        chk_all();
        latch_set();
        chk_all();
        read_status(1'b0);
        mst_u.tx_q.push_back(OPC_LATCH_CLEAR);
        mst_u.frame(8, 1'b0);
        wel_m = 1'b0;
        chk_all();
        for (int g = 0; g < 4; g++) begin
            r = rnd();
            v = r[7:0];
            v[1] = 1'b1;
            v[BIT_GUARD_HI:BIT_GUARD_LO] = g[1:0];
            v[BIT_PIN_EN] = g[0];
            set_wp(1'b1);
            status_wr(v, 16);
            chk_all();
            set_wp(r[9]);
            latch_set();
            mem_burst({r[15:10], starts[g]}, 4, 2 * g + 1);
            chk_all();
        end
        set_wp(1'b1);
        status_wr(8'h84, 16);
        set_wp(1'b0);
        status_wr(8'h08, 16);
        chk_all();
        set_wp(1'b1);
        status_wr(8'h08, 16);
        chk_all();
        set_wp(1'b0);
        status_wr(8'h0C, 16);
        chk_all();
        status_wr(8'h80, 13);
        chk_all();
        foreach (bad_ops[k]) begin
            latch_set();
            mst_u.tx_q = {bad_ops[k], 8'h00, 8'h00, 8'h10, 8'hA5};
            mst_u.frame(40, 1'b0);
            if (bad_ops[k] == OPC_SECTOR_WRITE || bad_ops[k] == OPC_SERNUM_WRITE) begin
                wel_m = 1'b0;
            end
            chk_stat("so_oe_seen", 8'h00, {7'h00, mst_u.oe_seen});
            chk_all();
        end
        read_status(1'b1);
        chk_stat("mem_pending", 8'h00, 8'(exp_q.size()));
        stop_test();
    end
endmodule
